// >>> tmr_pkg.sv
// shared constants and types of the eight-bit timer with shared prescaler
package tmr_pkg;

   // ------------------------------------------------------------
   // widths, values after reset and the wrap value
   // ------------------------------------------------------------
   localparam int         COUNT_W        = 8;
   localparam int         PRE_W          = 8;
   localparam logic [7:0] COUNT_RST      = 8'h00;
   localparam logic [7:0] PRE_RST        = 8'h00;
   localparam logic [7:0] COUNT_WRAP     = 8'hff;
   localparam logic [2:0] SYNC_RST       = 3'h0;

   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int         CLK_PERIOD_NS  = 20;
   // one instruction cycle is four clocks, one per phase
   localparam int         PHASES         = 4;
   localparam int         INSTR_NS       = PHASES * CLK_PERIOD_NS;
   // instruction cycles of increment hold-off after a count write
   localparam logic [1:0] INHIBIT_CYCLES = 2'h2;
   localparam logic [1:0] INHIBIT_NONE   = 2'h0;

   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   // instruction phase clocks, one-hot
   typedef enum logic [3:0] {
      PH_Q1 = 4'h1,
      PH_Q2 = 4'h2,
      PH_Q3 = 4'h4,
      PH_Q4 = 4'h8
   } phase_t;

   // option bits that steer the timer
   typedef struct packed {
      logic       clock_source_select;
      logic       source_edge_select;
      logic       prescaler_assign;
      logic [2:0] prescale_rate;
   } option_t;

   // write strobe with its data, for the count and the flag
   typedef struct packed {
      logic       wr;
      logic [7:0] data;
   } count_write_t;

   typedef struct packed {
      logic wr;
      logic data;
   } flag_write_t;

endpackage

// >>> pin_sync.sv
// three-stage pin synchroniser with an agreement filter
`timescale 1ns/10ps
`default_nettype none

module pin_sync
   import tmr_pkg::*;
(
   input  wire logic i_clk,
   input  wire logic i_rst,
   input  wire logic i_pin,
   output var  logic o_level
);

   // ------------------------------------------------------------
   // synchroniser chain
   // ------------------------------------------------------------
   logic [2:0] sync_q;
   logic       level_q;

   // stage 0 is read only by stage 1
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         sync_q <= SYNC_RST;
      end else begin
         sync_q <= {sync_q[1:0], i_pin};
      end
   end

   // a change counts once the last two stages agree
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         level_q <= 1'b0;
      end else if (sync_q[1] == sync_q[2]) begin
         level_q <= sync_q[2];
      end
   end

   assign o_level = level_q;

endmodule

`default_nettype wire

// >>> primary_timer.sv
// eight-bit timer/counter with a prescaler shared with the watchdog
`timescale 1ns/10ps
`default_nettype none

// Contract
// - the count register is eight bits, readable and writable.
// - timer mode with no prescaler counts once per instruction cycle.
// - a count write suppresses increments for the next two instruction cycles.
// - counter mode advances on external input edges chosen by edge select.
// - one prescaler serves timer or watchdog, assign bit 0 means timer.
// - assigned to timer, the rate field picks 1:2 up to 1:256.
// - undivided 1:1 counting only when the prescaler serves the watchdog.
// - the prescaler count is never readable or writable by software.
// - assigned to timer, any count write clears the prescaler.
// - assigned to watchdog, the watchdog clear also clears the prescaler.
// - wrap from FFh to 00h sets the overflow flag regardless of enable.
// - the flag stays set until software writes it to zero.
// - flag and enable both set raise the interrupt request.
// - count is frozen in sleep, so overflow cannot wake the core.
// - counter mode syncs prescaler output by sampling on Q2 and Q4.
// - the shared prescaler is an eight-bit counter in the assigned path.
module primary_timer
   import tmr_pkg::*;
(
   input  wire logic         i_clk,
   input  wire logic         i_rst,
   input  wire option_t      i_option,
   input  wire count_write_t i_count_write,
   input  wire flag_write_t  i_flag_write,
   input  wire logic         i_overflow_irq_enable,
   input  wire logic         i_watchdog_clear,
   input  wire logic         i_watchdog_tick,
   input  wire logic         i_sleep,
   input  wire logic         i_external_count_input,
   output var  logic [7:0]   o_count,
   output var  logic         o_overflow_flag,
   output var  logic         o_irq,
   output var  logic         o_watchdog_tick
);

   // ------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------
   phase_t     phase_q;
   phase_t     phase_d;
   logic [7:0] count_q;
   logic [7:0] count_d;
   logic [7:0] pre_q;
   logic [7:0] pre_d;
   logic [1:0] inhibit_q;
   logic [1:0] inhibit_d;
   logic       flag_q;
   logic       flag_d;
   logic       irq_q;
   logic       wdt_tick_q;
   logic       pend_q;
   logic       pend_d;
   logic       ext_level;
   logic       ext_prev_q;

   // ------------------------------------------------------------
   // decode of the option bits, the count write strobe and the phase
   // ------------------------------------------------------------
   wire        counter_mode = i_option.clock_source_select;
   wire        pre_to_wdt   = i_option.prescaler_assign;
   wire        pre_to_tmr   = ~pre_to_wdt;
   wire        count_wr     = i_count_write.wr;
   wire        instr_end    = (phase_q == PH_Q4);
   wire        sample_phase = (phase_q == PH_Q2) || (phase_q == PH_Q4);

   // ------------------------------------------------------------
   // instruction phase sequencer
   // ------------------------------------------------------------
   // phases stop in sleep, as the core clocks do
   always_comb begin
      case (phase_q)
         PH_Q1:   phase_d = PH_Q2;
         PH_Q2:   phase_d = PH_Q3;
         PH_Q3:   phase_d = PH_Q4;
         PH_Q4:   phase_d = PH_Q1;
         default: phase_d = PH_Q1;
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         phase_q <= PH_Q1;
      end else if (!i_sleep) begin
         phase_q <= phase_d;
      end
   end

   // ------------------------------------------------------------
   // external count input
   // ------------------------------------------------------------
   pin_sync u_pin_sync (
      .i_clk   (i_clk),
      .i_rst   (i_rst),
      .i_pin   (i_external_count_input),
      .o_level (ext_level)
   );

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         ext_prev_q <= 1'b0;
      end else begin
         ext_prev_q <= ext_level;
      end
   end

   // edge select picks rising or falling
   wire ext_rise = ext_level & ~ext_prev_q;
   wire ext_fall = ~ext_level & ext_prev_q;
   wire ext_edge = i_option.source_edge_select ? ext_fall : ext_rise;

   // ------------------------------------------------------------
   // count source
   // ------------------------------------------------------------
   // timer mode ticks once per instruction cycle, at its end
   wire tmr_src  = counter_mode ? ext_edge : instr_end;
   // the timer source is dead in sleep, which freezes its prescaler
   wire src_evt  = tmr_src & ~i_sleep;

   // ------------------------------------------------------------
   // shared prescaler
   // ------------------------------------------------------------
   // one counter, fed by whichever unit owns it
   wire pre_in   = pre_to_wdt ? i_watchdog_tick : src_evt;

   // watchdog ratio 2^n, timer ratio 2^(n+1)
   wire [8:0] wdt_mask_w = (9'h001 << i_option.prescale_rate) - 9'h001;
   wire [7:0] wdt_mask   = wdt_mask_w[7:0];
   wire [7:0] tmr_mask   = {wdt_mask[6:0], 1'b1};
   wire [7:0] pre_mask   = pre_to_wdt ? wdt_mask : tmr_mask;

   // rollover of the selected low bits is the divided event
   wire pre_roll = pre_in & ((pre_q & pre_mask) == pre_mask);

   // clears come from the owner: count write or watchdog clear
   wire pre_clr_tmr = pre_to_tmr & count_wr;
   wire pre_clr_wdt = pre_to_wdt & i_watchdog_clear;
   wire pre_clr     = pre_clr_tmr | pre_clr_wdt;

   // the prescaler has no read or write path at all
   always_comb begin
      pre_d = pre_q;
      if (pre_clr) begin
         pre_d = PRE_RST;
      end else if (pre_in) begin
         pre_d = pre_q + 8'h01;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         pre_q <= PRE_RST;
      end else begin
         pre_q <= pre_d;
      end
   end

   // watchdog sees the raw tick when the timer owns the prescaler
   wire wdt_evt = pre_to_wdt ? (pre_roll & ~pre_clr) : i_watchdog_tick;

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         wdt_tick_q <= 1'b0;
      end else begin
         wdt_tick_q <= wdt_evt;
      end
   end

   // ------------------------------------------------------------
   // divided count event
   // ------------------------------------------------------------
   // undivided only while the watchdog owns the prescaler
   wire div_evt = pre_to_wdt ? src_evt : (pre_roll & ~pre_clr);

   // ------------------------------------------------------------
   // counter-mode sampling on Q2 and Q4
   // ------------------------------------------------------------
   // a pending edge is taken at the next Q2 or Q4; set wins
   always_comb begin
      pend_d = pend_q;
      if (sample_phase && !i_sleep) begin
         pend_d = 1'b0;
      end
      if (counter_mode && div_evt) begin
         pend_d = 1'b1;
      end
      if (!counter_mode) begin
         pend_d = 1'b0;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         pend_q <= 1'b0;
      end else begin
         pend_q <= pend_d;
      end
   end

   wire ext_take = pend_q & sample_phase & ~i_sleep;

   // ------------------------------------------------------------
   // increment hold-off after a count write
   // ------------------------------------------------------------
   // two instruction-cycle ends must pass before counting resumes
   always_comb begin
      inhibit_d = inhibit_q;
      if (count_wr) begin
         inhibit_d = INHIBIT_CYCLES;
      end else if (instr_end && !i_sleep && inhibit_q != INHIBIT_NONE) begin
         inhibit_d = inhibit_q - 2'h1;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         inhibit_q <= INHIBIT_NONE;
      end else begin
         inhibit_q <= inhibit_d;
      end
   end

   // ------------------------------------------------------------
   // count register
   // ------------------------------------------------------------
   wire tmr_raw = counter_mode ? ext_take : div_evt;
   // edges that land during the hold-off are dropped, not delayed
   wire tmr_inc = tmr_raw & ~i_sleep & (inhibit_q == INHIBIT_NONE) & ~count_wr;
   wire wrap    = tmr_inc & (count_q == COUNT_WRAP);

   // a write takes priority over a same-cycle increment
   always_comb begin
      count_d = count_q;
      if (count_wr) begin
         count_d = i_count_write.data;
      end else if (tmr_inc) begin
         count_d = count_q + 8'h01;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         count_q <= COUNT_RST;
      end else begin
         count_q <= count_d;
      end
   end

   // ------------------------------------------------------------
   // overflow flag and interrupt request
   // ------------------------------------------------------------
   // a wrap in the cycle of a software clear still sets the flag
   always_comb begin
      flag_d = flag_q;
      if (i_flag_write.wr) begin
         flag_d = i_flag_write.data;
      end
      if (wrap) begin
         flag_d = 1'b1;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         flag_q <= 1'b0;
         irq_q  <= 1'b0;
      end else begin
         flag_q <= flag_d;
         irq_q  <= flag_d & i_overflow_irq_enable;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign o_count         = count_q;
   assign o_overflow_flag = flag_q;
   assign o_irq           = irq_q;
   assign o_watchdog_tick = wdt_tick_q;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   AST_WRITE_LOADS:
   assert property (@(posedge i_clk) disable iff (i_rst)
      count_wr |=> (count_q == $past(i_count_write.data)))
      else $error("count write not loaded");

   AST_HOLD_OFF:
   assert property (@(posedge i_clk) disable iff (i_rst)
      (inhibit_q != INHIBIT_NONE && !count_wr) |=> (count_q == $past(count_q)))
      else $error("count moved during write hold-off");

   AST_HOLD_SPAN:
   assert property (@(posedge i_clk) disable iff (i_rst)
      (count_wr && instr_end && !i_sleep) ##1 (!count_wr && !i_sleep)[*4]
      |=> (inhibit_q == 2'h1))
      else $error("hold-off did not span two instruction cycles");

   AST_TIMER_RATE:
   assert property (@(posedge i_clk) disable iff (i_rst)
      (!counter_mode && pre_to_wdt && instr_end && !i_sleep && !count_wr
       && inhibit_q == INHIBIT_NONE) |=> (count_q == $past(count_q) + 8'h01))
      else $error("timer mode missed its instruction-cycle increment");

   AST_WRAP_FLAG:
   assert property (@(posedge i_clk) disable iff (i_rst)
      (tmr_inc && count_q == COUNT_WRAP) |=> (flag_q && count_q == 8'h00))
      else $error("wrap did not set overflow flag");

   AST_FLAG_STICKY:
   assert property (@(posedge i_clk) disable iff (i_rst)
      (flag_q && !(i_flag_write.wr && !i_flag_write.data)) |=> flag_q)
      else $error("overflow flag dropped without a clearing write");

   AST_IRQ:
   assert property (@(posedge i_clk) disable iff (i_rst)
      (flag_q && !i_flag_write.wr) |=> (o_irq == $past(i_overflow_irq_enable)))
      else $error("interrupt request disagrees with flag and enable");

   AST_SLEEP_FREEZE:
   assert property (@(posedge i_clk) disable iff (i_rst)
      (i_sleep && !count_wr) |=> $stable(count_q))
      else $error("count moved in sleep");

   AST_PRE_CLR_WRITE:
   assert property (@(posedge i_clk) disable iff (i_rst)
      (count_wr && pre_to_tmr) |=> (pre_q == PRE_RST))
      else $error("count write did not clear prescaler");

   AST_PRE_CLR_WDT:
   assert property (@(posedge i_clk) disable iff (i_rst)
      (i_watchdog_clear && pre_to_wdt) |=> (pre_q == PRE_RST))
      else $error("watchdog clear did not clear prescaler");

   AST_EXT_PHASE:
   assert property (@(posedge i_clk) disable iff (i_rst)
      (counter_mode && tmr_inc) |-> (phase_q == PH_Q2 || phase_q == PH_Q4))
      else $error("counter mode increment off the sampling phases");

endmodule

`default_nettype wire

// >>> ext_clk_src.sv
// model of the external clock source that drives the count input pin
`timescale 1ns/10ps
`default_nettype none

module ext_clk_src (
   input  wire logic i_clk,
   output var  logic o_pin
);
   // ------------------------------------------------------------
   // pin level
   // ------------------------------------------------------------
   // the pin is driven at all times and stands still between bursts
   initial o_pin = 1'b0;

   // k level changes, each level held h clocks; h of 3 or more keeps the minimum high and low time
   task automatic run(input int k, input int h);
      repeat (k) begin
         repeat (h) @(negedge i_clk);
         o_pin = ~o_pin;
      end
   endtask
endmodule
`default_nettype wire

// >>> eight_bit_timer_shared_prescaler_tb.sv
// self-checking bench for the eight-bit timer with shared prescaler
`timescale 1ns/10ps
`default_nettype none

module eight_bit_timer_shared_prescaler_tb
   import tmr_pkg::*;
;
   logic         clk;
   logic         rst;
   option_t      opt;
   count_write_t cw;
   flag_write_t  fw;
   logic         irq_en;
   logic         wd_clr;
   logic         wd_tick;
   logic         sleep_lvl;
   logic         pin;
   logic [7:0]   count;
   logic         flag;
   logic         irq;
   logic         wd_out;
   int           n_mismatch   = 0;
   int           total_checks = 0;
   int           wd_seen      = 0;
   int           exp_count    = 0;
   int           clks         = 0;
   int           seed         = 32'h78d8911e;

   // ------------------------------------------------------------
   // clock, design and partner
   // ------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   primary_timer DUT (
      .i_clk                  (clk),
      .i_rst                  (rst),
      .i_option               (opt),
      .i_count_write          (cw),
      .i_flag_write           (fw),
      .i_overflow_irq_enable  (irq_en),
      .i_watchdog_clear       (wd_clr),
      .i_watchdog_tick        (wd_tick),
      .i_sleep                (sleep_lvl),
      .i_external_count_input (pin),
      .o_count                (count),
      .o_overflow_flag        (flag),
      .o_irq                  (irq),
      .o_watchdog_tick        (wd_out)
   );

   ext_clk_src u_src (
      .i_clk (clk),
      .o_pin (pin)
   );

   // watchdog pulses, scaled or raw, counted as they leave the design
   // sampled mid-cycle, where each one-cycle pulse has settled
   always @(negedge clk) if (wd_out === 1'b1) wd_seen <= wd_seen + 1;

   // ------------------------------------------------------------
   // checks and drivers
   // ------------------------------------------------------------
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %0h seen %0h", name, exp, got);
      end
   endtask

   task automatic chk_rng(input string name, input int lo, input int hi, input int got);
      total_checks++;
      if (got < lo || got > hi) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %0d..%0d seen %0d", name, lo, hi, got);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask

   // strobe held high across a second write so it is never dropped and raised in one step
   task automatic wr_count(input logic [7:0] d, input bit twice);
      cw = '{wr: 1'b1, data: d};
      @(negedge clk);
      if (twice) begin
         cw.data = ~d;
         @(negedge clk);
      end
      exp_count = int'(cw.data);
      cw.wr = 1'b0;
      chk("count after write", exp_count, count);
   endtask

   // clocks until the count moves; every move is one step of the model
   task automatic next_change(input int max);
      logic [7:0] old;
      old = count;
      clks = 0;
      do begin
         @(negedge clk);
         clks++;
      end while (count === old && clks < max);
      exp_count = (exp_count + 1) % 256;
      chk("count step", exp_count, count);
   endtask

   task automatic wr_flag(input logic v);
      fw = '{wr: 1'b1, data: v};
      @(negedge clk);
      fw.wr = 1'b0;
      chk("flag after write", v, flag);
   endtask

   task automatic wd_pulse(input int n);
      repeat (n) begin
         wd_tick = 1'b1;
         @(negedge clk);
         wd_tick = 1'b0;
         @(negedge clk);
      end
   endtask

   task automatic wd_clear;
      wd_clr = 1'b1;
      @(negedge clk);
      wd_clr = 1'b0;
   endtask

   task automatic results;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      int d;
      int k;
      int e;
      int n;
      int div;
      int base;
      rst = 1'b1;
      opt = '{1'b0, 1'b0, 1'b1, 3'h0};
      cw = '0;
      fw = '0;
      irq_en = 1'b0;
      wd_clr = 1'b0;
      wd_tick = 1'b0;
      sleep_lvl = 1'b0;
      repeat (4) @(negedge clk);
      rst = 1'b0;
      tick(1);
      chk("count at reset", 0, count);
      chk("flag at reset", 0, flag);
      chk("irq at reset", 0, irq);
      // undivided timer whatever the rate field, and hold-off after plain and back-to-back writes
      opt.prescale_rate = 3'($random(seed));
      repeat (8) begin
         d = $random(seed);
         tick(int'(d[9:8]) + 1);
         wr_count(d[7:0], d[10]);
         next_change(20);
         chk_rng("hold-off clocks", 9, 12, clks);
         next_change(8);
         chk("undivided period", 4, clks);
      end
      // wrap with the enable on and off; flag sticks until cleared
      for (e = 1; e >= 0; e--) begin
         irq_en = e[0];
         wr_count(8'hfd, 1'b0);
         repeat (3) next_change(20);
         chk("flag at wrap", 1, flag);
         tick(1);
         chk("irq after wrap", e, irq);
         next_change(8);
         chk("flag held", 1, flag);
         wr_flag(1'b0);
         tick(1);
         chk("irq after clear", 0, irq);
      end
      irq_en = 1'b1;
      wr_flag(1'b1);
      tick(1);
      chk("irq from set flag", 1, irq);
      wr_flag(1'b0);
      // sleep right after reaching ff: no wrap may happen until wake
      wr_count(8'hfc, 1'b0);
      repeat (3) next_change(20);
      sleep_lvl = 1'b1;
      tick(40);
      chk("count in sleep", 8'hff, count);
      chk("flag in sleep", 0, flag);
      sleep_lvl = 1'b0;
      next_change(8);
      chk("flag after wake", 1, flag);
      wr_flag(1'b0);
      // prescaler moved to the timer: every rate, then a clear in mid-period
      wd_clear();
      for (k = 0; k < 8; k++) begin
         opt = '{1'b0, 1'b0, 1'b0, k[2:0]};
         wr_count(8'h00, 1'b0);
         next_change(1100);
         next_change(1100);
         chk("prescaled period", 8 << k, clks);
      end
      tick(600);
      wr_count(8'h40, 1'b0);
      next_change(1100);
      chk_rng("first step after clear", 1020, 1034, clks);
      // watchdog ticks pass raw while the timer holds the prescaler
      base = wd_seen;
      wd_pulse(5);
      tick(3);
      chk("raw watchdog ticks", base + 5, wd_seen);
      wd_clear();
      wr_count(8'h00, 1'b0);
      opt.prescaler_assign = 1'b1;
      wd_clear();
      opt.prescale_rate = 3'h2;
      base = wd_seen;
      wd_pulse(3);
      wd_clear();
      wd_pulse(3);
      tick(3);
      chk("ticks after clear", base, wd_seen);
      wd_pulse(9);
      tick(3);
      chk("scaled watchdog ticks", base + 3, wd_seen);
      // the count ran freely since the last write, so reload the model first
      wr_count(8'h80, 1'b0);
      next_change(20);
      next_change(8);
      chk("undivided with watchdog", 4, clks);
      // counter mode: both edges, undivided and through the prescaler
      for (e = 0; e < 6; e++) begin
         div = (e < 2) ? 1 : (e < 4) ? 2 : 4;
         opt = '{1'b1, e[0], (e < 2), (e < 4) ? 3'h0 : 3'h1};
         wr_count(8'h00, 1'b0);
         tick(16);
         k = 6 + ($random(seed) & 15);
         n = (pin == e[0]) ? (k + 1) / 2 : k / 2;
         u_src.run(k, 3 + ($random(seed) & 3));
         tick(20);
         chk("edge count", n / div, count);
      end
      results();
   end

   // ------------------------------------------------------------
   // hang guard, a few times the longest expected run of about 7000 clocks
   // ------------------------------------------------------------
   initial begin
      #400000;
      n_mismatch++;
      results();
   end
endmodule
`default_nettype wire
